// File: bsc_link_if.sv
// three-wire serial link between host clock master and encoder slave
`timescale 1ns/1ps
`default_nettype none
interface bsc_link_if;
   logic ma;
   logic sl;
   logic sli;
   modport master (output ma, input sl, input sli);
   modport slave (input ma, output sl, output sli);
endinterface
`default_nettype wire

// File: bsc_link_sva.sv
// assertions on the encoder link wires and measurement timing
`timescale 1ns/1ps
`default_nettype none
module bsc_link_sva #(
   parameter int unsigned MEAS_CYC_P = bsc_pkg::MEAS_CYC,
   parameter int unsigned MEAS_TO_CYC_P = bsc_pkg::MEAS_TO_CYC
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic ma,
   input wire logic sl,
   input wire logic sli,
   input wire logic meas_busy_o,
   input wire logic frame_active_o
);
   logic ma_q;
   int idle_q;
   int busy_q;
   int since_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // ------------------------------------------------------------
   // helper counters: link quiet time, busy length, trigger spacing
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ma_q <= 1'h1;
         idle_q <= 0;
         busy_q <= 0;
         since_q <= 0;
      end else begin
         ma_q <= ma;
         idle_q <= (ma != ma_q) ? 0 : idle_q + 1;
         busy_q <= meas_busy_o ? busy_q + 1 : 0;
         since_q <= (meas_busy_o && busy_q == 0) ? 0 : since_q + 1;
      end
   end
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   sequence frame_start_s;
      $fell(ma) && !frame_active_o;
   endsequence
   sli_tied_a: assert property (sli == 1'h0)
      else $error("slave input not held low");
   ack_low_a: assert property (frame_start_s |-> ##[1:8] !sl)
      else $error("no acknowledge after frame start");
   bit_launch_a: assert property ($rose(sl) |-> ma)
      else $error("data changed while link clock low");
   trig_a: assert property (frame_start_s ##0 !meas_busy_o |-> ##[1:8] meas_busy_o)
      else $error("frame start did not trigger a measurement");
   meas_len_a: assert property ($fell(meas_busy_o) |-> busy_q inside {[MEAS_CYC_P:MEAS_CYC_P*19/18]})
      else $error("measurement length out of range");
   auto_trig_a: assert property (since_q <= MEAS_TO_CYC_P * 29 / 27)
      else $error("no automatic measurement trigger");
   sl_stuck_a: assert property (!(!sl && idle_q > 1000))
      else $error("data line low past the timeout");
   tmo_min_a: assert property ($rose(sl) && idle_q > 100 |-> idle_q >= 750)
      else $error("timeout ended too early");
   ma_rate_a: assert property ($changed(ma) |=> $stable(ma) [*8])
      else $error("link clock too fast");
   idle_a: assert property (!frame_active_o && !$past(frame_active_o) |-> sl)
      else $error("data line not high while idle");
endmodule
`default_nettype wire

// File: bsc_master_end.sv
// host end of the link: clock generator, frame receiver and apb registers
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module bsc_master_end (
   input wire logic clk,
   input wire logic arst_n,
   bsc_link_if.master link,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import bsc_pkg::*;

   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_RUN = 2'b01,
      H_WAITLO = 2'b10,
      H_WAITHI = 2'b11
   } bsc_mst_state_type;

   localparam logic [5:0] HALF = 6'(MA_HALF_CYC - 1);
   localparam logic [5:0] FIRST_SAMPLE = 6'(PROC_BITS + 2);
   localparam logic [5:0] LAST_FALL = 6'(LAST_BIT + 1);

   bsc_mst_state_type st_q, st_d;
   logic sl1_q, sl1_d, sl2_q, sl2_d, sl3_q, sl3_d, sl_s_q, sl_s_d;
   logic ma_q, ma_d;
   logic [5:0] div_q, div_d, fall_q, fall_d;
   logic [SHIFT_W-1:0] rx_q, rx_d;
   logic [POS_W-1:0] pos_q, pos_d;
   logic [5:0] stat_q, stat_d;
   logic start;
   logic [31:0] prdata_d;
   logic pready_d, pslverr_d;

   // ----------------------------------------------------------------
   // apb slave: three-cycle access with one wait state, register file
   // ----------------------------------------------------------------
   always_comb begin
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      prdata_d = 32'h0000_0000;
      start = 1'b0;
      if (psel && penable && !pready) begin
         pready_d = 1'b1;
         case (paddr)
            REG_CTRL: prdata_d = 32'h0000_0000;
            REG_STATUS: prdata_d = 32'(stat_q);
            REG_POS: prdata_d = 32'(pos_q);
            default: pslverr_d = 1'b1;
         endcase
      end
      if (psel && penable && pready && pwrite && paddr == REG_CTRL) begin
         start = pwdata[CTRL_START];
      end
   end

   // ----------------------------------------------------------------
   // link clock divider and frame receiver
   // ----------------------------------------------------------------
   always_comb begin
      sl1_d = link.sl;
      sl2_d = sl1_q;
      sl3_d = sl2_q;
      sl_s_d = sl_s_q;
      if (sl2_q == sl3_q) begin
         sl_s_d = sl3_q;
      end
      st_d = st_q;
      ma_d = ma_q;
      div_d = div_q;
      fall_d = fall_q;
      rx_d = rx_q;
      pos_d = pos_q;
      stat_d = stat_q;
      stat_d[ST_BUSY] = (st_q != H_IDLE);
      case (st_q)
         H_IDLE: begin
            if (start && sl_s_q) begin
               // only this end drives the link clock
               st_d = H_RUN;
               ma_d = 1'b0;
               div_d = 6'h00;
               fall_d = 6'h01;
               stat_d[ST_HAVE] = 1'b0;
               stat_d[ST_BUSY] = 1'b1;
            end
         end
         H_RUN: begin
            if (div_q == HALF) begin
               div_d = 6'h00;
               if (ma_q) begin
                  ma_d = 1'b0;
                  fall_d = fall_q + 1'b1;
                  if (fall_q + 1'b1 >= FIRST_SAMPLE) begin
                     rx_d = {rx_q[SHIFT_W-2:0], sl_s_q};
                  end
               end else begin
                  ma_d = 1'b1;
                  if (fall_q == LAST_FALL) begin
                     st_d = H_WAITLO;
                  end
               end
            end else begin
               div_d = div_q + 1'b1;
            end
            if (st_d == H_WAITLO) begin
               pos_d = rx_q[SCD_W-1:CRC_W+2];
               stat_d[ST_POS_VALID] = rx_q[CRC_W+1];
               stat_d[ST_TURN_VALID] = rx_q[CRC_W];
               stat_d[ST_FRAME_ERR] = !rx_q[SHIFT_W-1] || rx_q[SHIFT_W-2];
               // crc is sent inverted
               stat_d[ST_CRC_ERR] =
                  bsc_crc6(rx_q[SCD_W-1:CRC_W]) != ~rx_q[CRC_W-1:0];
               stat_d[ST_HAVE] = 1'b1;
            end
         end
         H_WAITLO: begin
            if (!sl_s_q) begin
               st_d = H_WAITHI;
            end
         end
         H_WAITHI: begin
            if (sl_s_q) begin
               st_d = H_IDLE;
            end
         end
         default: st_d = H_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= H_IDLE;
         sl1_q <= 1'b1;
         sl2_q <= 1'b1;
         sl3_q <= 1'b1;
         sl_s_q <= 1'b1;
         ma_q <= 1'b1;
         div_q <= 6'h00;
         fall_q <= 6'h00;
         rx_q <= '0;
         pos_q <= '0;
         stat_q <= 6'h00;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         st_q <= st_d;
         sl1_q <= sl1_d;
         sl2_q <= sl2_d;
         sl3_q <= sl3_d;
         sl_s_q <= sl_s_d;
         ma_q <= ma_d;
         div_q <= div_d;
         fall_q <= fall_d;
         rx_q <= rx_d;
         pos_q <= pos_d;
         stat_q <= stat_d;
         prdata <= prdata_d;
         pready <= pready_d;
         pslverr <= pslverr_d;
      end
   end

   // 1 MHz link clock, within the allowed band
   assign link.ma = ma_q;
endmodule
`default_nettype wire

// File: bsc_pkg.sv
// shared constants and crc helper for the single-turn absolute-encoder link
`default_nettype none
package bsc_pkg;
   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_NS = 20;
   localparam int unsigned CLK_KHZ = 50000;
   localparam int unsigned LINK_TO_NS = 15000;
   localparam int unsigned MEAS_NS = 90000;
   localparam int unsigned MEAS_TO_NS = 135000;
   localparam int unsigned MA_KHZ = 1000;
   localparam int unsigned LINK_TO_CYC = (LINK_TO_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned MEAS_CYC = (MEAS_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned MEAS_TO_CYC = (MEAS_TO_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned MA_HALF_CYC = CLK_KHZ / (2 * MA_KHZ);
   localparam int unsigned CNT_W = 14;
   // ----------------------------------------------------------------
   // frame layout
   // ----------------------------------------------------------------
   localparam int unsigned PROC_BITS = 12;
   localparam int unsigned DATA_W = 24;
   localparam int unsigned CRC_W = 6;
   localparam int unsigned SCD_W = 30;
   localparam int unsigned SHIFT_W = 2 + SCD_W;
   localparam int unsigned LAST_BIT = PROC_BITS + SHIFT_W;
   localparam int unsigned POS_W = 22;
   localparam int unsigned POS_RES = 22;
   localparam int unsigned LJ_SHIFT = POS_W - POS_RES;
   // x^6 term implied by the register width
   localparam logic [5:0] CRC_POLY = 6'h03;
   localparam logic [5:0] CRC_INIT = 6'h00;
   // ----------------------------------------------------------------
   // host registers
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_POS = 8'h08;
   localparam int unsigned CTRL_START = 0;
   localparam int unsigned ST_BUSY = 0;
   localparam int unsigned ST_FRAME_ERR = 1;
   localparam int unsigned ST_CRC_ERR = 2;
   localparam int unsigned ST_POS_VALID = 3;
   localparam int unsigned ST_TURN_VALID = 4;
   localparam int unsigned ST_HAVE = 5;

   // serial crc, msb first, over the data area
   function automatic logic [5:0] bsc_crc6(input logic [DATA_W-1:0] data);
      logic [5:0] crc;
      logic fb;
      crc = CRC_INIT;
      for (int i = DATA_W - 1; i >= 0; i--) begin
         fb = data[i] ^ crc[5];
         crc = {crc[4:0], 1'b0} ^ (fb ? CRC_POLY : 6'h00);
      end
      return crc;
   endfunction
endpackage
`default_nettype wire

// File: bsc_slave_end.sv
// encoder end of the link: pipelined position frames clocked by the host
//
// Contract
// - host alone drives the link clock
// - one data bit on SL per clock cycle
// - slave input SLI held at zero
// - host clock between 600 and 2000 kHz
// - 15 to 20 us timeout after last edge
// - frame carries measurement triggered by previous frame
// - single-cycle data is exactly 30 bits
// - 12 clock cycles processing before data
// - data area is 24 bits
// - inverted 6-bit crc, poly 0x43, init zero
// - msb first, position, valid, turn flag last
// - low resolution position left-justified, zero filled
// - position valid flag; turn flag always one
// - point to point, single slave
// - unidirectional, no commands accepted
// - each new frame tries to trigger measurement
// - no retrigger while measurement in progress
// - measurement takes 90 to 95 us
// - auto trigger after 135 to 145 us
`timescale 1ns/1ps
`default_nettype none
module bsc_slave_end #(
   parameter int unsigned MEAS_CYC_P = bsc_pkg::MEAS_CYC,
   parameter int unsigned MEAS_TO_CYC_P = bsc_pkg::MEAS_TO_CYC
) (
   input wire logic clk,
   input wire logic arst_n,
   bsc_link_if.slave link,
   input wire logic [bsc_pkg::POS_RES-1:0] pos_i,
   input wire logic pos_ok_i,
   output logic meas_busy_o,
   output logic frame_active_o
);
   import bsc_pkg::*;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_FRAME = 1'b1
   } bsc_slv_state_type;

   localparam logic [CNT_W-1:0] MEAS_DONE = CNT_W'(MEAS_CYC_P - 1);
   localparam logic [CNT_W-1:0] MEAS_TO = CNT_W'(MEAS_TO_CYC_P - 1);
   localparam logic [CNT_W-1:0] LINK_TO = CNT_W'(LINK_TO_CYC - 1);
   localparam logic [5:0] PROC_END = 6'(PROC_BITS);
   localparam logic [5:0] BIT_END = 6'(LAST_BIT);

   bsc_slv_state_type st_q, st_d;
   logic ma1_q, ma1_d, ma2_q, ma2_d, ma3_q, ma3_d, ma_s_q, ma_s_d;
   logic ma_fall, ma_rise;
   logic sl_q, sl_d;
   logic [5:0] bit_q, bit_d;
   logic [SHIFT_W-1:0] shift_q, shift_d;
   logic [CNT_W-1:0] to_q, to_d;
   logic frame_start;
   logic [CNT_W-1:0] meas_q, meas_d;
   logic busy_q, busy_d;
   logic [POS_W-1:0] mpos_q, mpos_d, rpos_q, rpos_d;
   logic mok_q, mok_d, rok_q, rok_d;
   logic trig;
   logic [DATA_W-1:0] data_area;

   // ----------------------------------------------------------------
   // link side: clock sampling and frame shifter
   // ----------------------------------------------------------------
   always_comb begin
      ma1_d = link.ma;
      ma2_d = ma1_q;
      ma3_d = ma2_q;
      ma_s_d = ma_s_q;
      if (ma2_q == ma3_q) begin
         ma_s_d = ma3_q;
      end
      ma_fall = ma_s_q & ~ma_s_d;
      ma_rise = ~ma_s_q & ma_s_d;
      st_d = st_q;
      sl_d = sl_q;
      bit_d = bit_q;
      shift_d = shift_q;
      to_d = to_q;
      frame_start = 1'b0;
      // position msb first, then valid flag, turn flag fixed at one
      data_area = {rpos_q, rok_q, 1'b1};
      case (st_q)
         ST_IDLE: begin
            sl_d = 1'b1;
            if (ma_fall) begin
               // first falling clock edge opens a frame
               st_d = ST_FRAME;
               frame_start = 1'b1;
               sl_d = 1'b0;
               bit_d = 6'h00;
               to_d = '0;
               // start bit, zero cds, data area, inverted crc
               shift_d = {1'b1, 1'b0, data_area, ~bsc_crc6(data_area)};
            end
         end
         ST_FRAME: begin
            if (ma_fall || ma_rise) begin
               to_d = '0;
            end else begin
               to_d = to_q + 1'b1;
            end
            if (ma_rise) begin
               if (bit_q != 6'h3F) begin
                  bit_d = bit_q + 1'b1;
               end
               if (bit_q >= PROC_END && bit_q < BIT_END) begin
                  sl_d = shift_q[SHIFT_W-1];
                  shift_d = {shift_q[SHIFT_W-2:0], 1'b0};
               end else begin
                  // ack during processing, low again during timeout
                  sl_d = 1'b0;
               end
            end
            if (!ma_fall && !ma_rise && to_q == LINK_TO) begin
               st_d = ST_IDLE;
               sl_d = 1'b1;
            end
         end
         default: begin
            st_d = ST_IDLE;
            sl_d = 1'b1;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // measurement timing and result pipeline
   // ----------------------------------------------------------------
   always_comb begin
      // a frame triggers only if none is running; stale timer forces one
      trig = (frame_start && !busy_q) || (meas_q == MEAS_TO);
      meas_d = meas_q;
      mpos_d = mpos_q;
      mok_d = mok_q;
      rpos_d = rpos_q;
      rok_d = rok_q;
      if (trig) begin
         meas_d = '0;
         mpos_d = POS_W'(pos_i) << LJ_SHIFT;
         mok_d = pos_ok_i;
      end else if (meas_q != MEAS_TO) begin
         meas_d = meas_q + 1'b1;
      end
      if (!trig && meas_q == MEAS_DONE) begin
         // result published here is sent by the next frame
         rpos_d = mpos_q;
         rok_d = mok_q;
      end
      busy_d = trig || (meas_d < MEAS_DONE + 1'b1);
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= ST_IDLE;
         ma1_q <= 1'b1;
         ma2_q <= 1'b1;
         ma3_q <= 1'b1;
         ma_s_q <= 1'b1;
         sl_q <= 1'b1;
         bit_q <= 6'h00;
         shift_q <= '0;
         to_q <= '0;
         meas_q <= MEAS_TO;
         busy_q <= 1'b0;
         mpos_q <= '0;
         mok_q <= 1'b0;
         rpos_q <= '0;
         rok_q <= 1'b0;
      end else begin
         st_q <= st_d;
         ma1_q <= ma1_d;
         ma2_q <= ma2_d;
         ma3_q <= ma3_d;
         ma_s_q <= ma_s_d;
         sl_q <= sl_d;
         bit_q <= bit_d;
         shift_q <= shift_d;
         to_q <= to_d;
         meas_q <= meas_d;
         busy_q <= busy_d;
         mpos_q <= mpos_d;
         mok_q <= mok_d;
         rpos_q <= rpos_d;
         rok_q <= rok_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // the link has no return channel into the encoder
   assign link.sl = sl_q;
   assign link.sli = 1'b0;
   assign meas_busy_o = busy_q;
   assign frame_active_o = (st_q == ST_FRAME);
endmodule
`default_nettype wire

// File: tb.sv
// self-checking bench: host end and encoder end joined over the link
`timescale 1ns/1ps
`default_nettype none
module tb;
   import bsc_pkg::*;
   localparam int unsigned MEAS = 450;
   localparam int unsigned MEAS_TO = 675;
   logic clk;
   logic arst_n;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [21:0] pos;
   logic pos_ok;
   logic meas_busy;
   logic frame_active;
   logic [31:0] rnd;
   logic [44:0] fr;
   logic ma_d;
   logic [31:0] rd;
   logic err;
   logic [23:0] q[$];
   logic [23:0] e;
   int nf;
   int cyc;
   int miscompares;
   int n_tests;
   bsc_link_if link();
   bsc_slave_end #(.MEAS_CYC_P(MEAS), .MEAS_TO_CYC_P(MEAS_TO)) u_bsc_slave_end (
      .clk(clk), .arst_n(arst_n), .link(link), .pos_i(pos), .pos_ok_i(pos_ok),
      .meas_busy_o(meas_busy), .frame_active_o(frame_active));
   bsc_master_end u_bsc_master_end (.clk(clk), .arst_n(arst_n), .link(link),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   bsc_link_sva #(.MEAS_CYC_P(MEAS), .MEAS_TO_CYC_P(MEAS_TO)) u_sva (.clk(clk),
      .arst_n(arst_n), .ma(link.ma), .sl(link.sl), .sli(link.sli),
      .meas_busy_o(meas_busy), .frame_active_o(frame_active));
   // ------------------------------------------------------------
   // model helpers and bus tasks
   // ------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      for (int i = 0; i < 24; i++) begin
         s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
      end
      return s;
   endfunction
   function automatic logic [5:0] crc(input logic [23:0] d);
      logic [5:0] c;
      c = 6'h00;
      for (int i = 23; i >= 0; i--) begin
         c = {c[4:0], 1'h0} ^ ((d[i] ^ c[5]) ? 6'h03 : 6'h00);
      end
      return c;
   endfunction
   task automatic end_of_test();
      if (miscompares == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk_word(input string nm, input logic [31:0] x, input logic [31:0] g);
      n_tests++;
      if (x !== g) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic chk_frame(input logic [44:0] x, input logic [44:0] g);
      n_tests++;
      if (x !== g) begin
         miscompares++;
         $display("Error frame expected %h seen %h", x, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
   endtask
   task automatic frame(input int gap);
      logic [23:0] v;
      rnd = lfsr(rnd);
      v = {rnd[21:0], rnd[22], 1'h1};
      pos <= v[23:2];
      pos_ok <= v[1];
      q.push_back(v);
      e = q.pop_front();
      nf = 0;
      apb(1'h1, REG_CTRL, 32'h1);
      apb(1'h0, REG_STATUS, 32'h0);
      chk_word("busy", 32'h1, rd & 32'h1);
      apb(1'h1, REG_CTRL, 32'h1);
      // poll the host status until the frame and its timeout are over
      do begin
         apb(1'h0, REG_STATUS, 32'h0);
      end while (rd[ST_BUSY] !== 1'h0);
      while (frame_active !== 1'h0) @(posedge clk);
      chk_frame({1'h1, 12'h000, 2'h2, e, ~crc(e)}, fr);
      chk_word("falling edges", 32'h2D, 32'(nf));
      apb(1'h0, REG_POS, 32'h0);
      chk_word("position", {10'h000, e[23:2]}, rd);
      apb(1'h0, REG_STATUS, 32'h0);
      chk_word("status", {26'h0, 2'h3, e[1], 3'h0}, rd);
      repeat (gap) @(posedge clk);
   endtask
   // ------------------------------------------------------------
   // clock, wire monitor, timeout and main sequence
   // ------------------------------------------------------------
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   always @(negedge clk) begin
      if (ma_d === 1'h1 && link.ma === 1'h0) begin
         fr = {fr[43:0], link.sl};
         nf++;
      end
      ma_d = link.ma;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         miscompares++;
         end_of_test();
      end
   end
   initial begin
      arst_n = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      ma_d = 1'h1;
      fr = 45'h0;
      rnd = lfsr(32'h0000097E);
      pos = rnd[21:0];
      pos_ok = rnd[22];
      q.push_back({rnd[21:0], rnd[22], 1'h1});
      repeat (20) @(posedge clk);
      arst_n <= 1'h1;
      repeat (MEAS + 10) @(posedge clk);
      apb(1'h0, REG_STATUS, 32'h0);
      chk_word("idle status", 32'h0, rd);
      for (int i = 0; i < 2; i++) begin
         apb(i[0], 8'h0C, 32'hFFFFFFFF);
         chk_word("unmapped error", 32'h1, {31'h0, err});
         chk_word("unmapped data", 32'h0, rd);
      end
      for (int k = 0; k < 6; k++) begin
         frame(k * 300);
      end
      apb(1'h1, REG_STATUS, 32'hFFFFFFFF);
      apb(1'h0, REG_STATUS, 32'h0);
      chk_word("status kept", {26'h0, 2'h3, e[1], 3'h0}, rd);
      end_of_test();
   end
endmodule
`default_nettype wire
